// ---- nandh_defs.vh ----
// constants of the nand host controller: register offsets, fields, kinds, timing
// assumes a 40 MHz core clock and byte addressing on the avalon slave
`ifndef NANDH_DEFS_VH
`define NANDH_DEFS_VH

// register byte offsets
`define NH_OFF_CTRL      5'h00
`define NH_OFF_OP        5'h04
`define NH_OFF_COLUMN    5'h08
`define NH_OFF_ROW       5'h0C
`define NH_OFF_WDATA     5'h10
`define NH_OFF_RDATA     5'h14
`define NH_OFF_STATUS    5'h18

// control register fields and reset value
`define NH_CTRL_X16      0
`define NH_CTRL_PROTECT  1
`define NH_CTRL_CE       2
`define NH_CTRL_RESET    3'h0

// operation register fields
`define NH_OP_CMD_MSB    7
`define NH_OP_KIND_LSB   8
`define NH_OP_KIND_MSB   10

// operation kinds
`define NH_K_CMD         3'h0
`define NH_K_ADDR        3'h1
`define NH_K_WRITE       3'h2
`define NH_K_READ        3'h3
`define NH_K_STATUS      3'h4
`define NH_K_POLL        3'h5
`define NH_K_WAITRB      3'h6

// status_reg layout as seen on the device
`define NH_SR_PROTECT    7
`define NH_SR_CACHE_IDLE 6
`define NH_SR_ARRAY_IDLE 5
`define NH_SR_EARLY_FAIL 1
`define NH_SR_CUR_FAIL   0
`define NH_SR_RESET      8'hE0
`define NH_CMD_STATUS    8'h70

// status register of the controller itself
`define NH_ST_BUSY       0
`define NH_ST_RB         1
`define NH_ST_SR_LSB     8
`define NH_ST_SR_MSB     15

// strobe timing
`define NH_CLK_MHZ           40
`define NH_T_STROBE_LOW_NS   50
`define NH_T_STROBE_HIGH_NS  50
`define NH_CYC_LOW   ((`NH_T_STROBE_LOW_NS * `NH_CLK_MHZ + 999) / 1000)
`define NH_CYC_HIGH  ((`NH_T_STROBE_HIGH_NS * `NH_CLK_MHZ + 999) / 1000)

`endif

// ---- nandh_strobe.v ----
// one bus-cycle strobe: low phase then high recovery phase
// assumes start is a one-cycle pulse given only while idle
`timescale 1ns/10ps
`default_nettype none
module nandh_strobe #(
    parameter LOW_CYC  = 2,
    parameter HIGH_CYC = 2
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst,
    // control
    input  wire        start,
    // results
    output wire        strobe_n,
    output wire        sample,
    output wire        done
);
    localparam [1:0] P_IDLE = 2'h0;
    localparam [1:0] P_LOW  = 2'h1;
    localparam [1:0] P_HIGH = 2'h2;

    reg [1:0] phase_q;
    reg [7:0] cnt_q;

    // phase and counter sequencing
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase_q <= P_IDLE;
            cnt_q   <= 8'h00;
        end else begin
            case (phase_q)
                P_IDLE: begin
                    if (start) begin
                        phase_q <= P_LOW;
                        cnt_q   <= LOW_CYC[7:0] - 8'h01;
                    end
                end
                P_LOW: begin
                    if (cnt_q == 8'h00) begin
                        phase_q <= P_HIGH;
                        cnt_q   <= HIGH_CYC[7:0] - 8'h01;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                P_HIGH: begin
                    if (cnt_q == 8'h00) begin
                        phase_q <= P_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    phase_q <= P_IDLE;
                end
            endcase
        end
    end

    // strobe low in low phase, sample on its last cycle
    assign strobe_n = (phase_q != P_LOW);
    assign sample   = (phase_q == P_LOW) && (cnt_q == 8'h00);
    assign done     = (phase_q == P_HIGH) && (cnt_q == 8'h00);
endmodule // nandh_strobe
`default_nettype wire

// ---- nandh_ctrl.v ----
// host controller for an asynchronous multiplexed nand flash device
// assumes an avalon-mm master on core_clk and device pins synchronous to it
// Notes on behaviour
// - x8 column: cycle one low, two bits 11..8
// - x16 column: word bits 7..0, then 10..8
// - cycles three, four carry page and block
// - host drives upper io low in addressing
// - cle marks command, ale marks address cycle
`timescale 1ns/10ps
`default_nettype none
`include "nandh_defs.vh"
module nandh_ctrl #(
    parameter LOW_CYC  = `NH_CYC_LOW,
    parameter HIGH_CYC = `NH_CYC_HIGH
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst,
    // avalon-mm slave
    input  wire [4:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output wire [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // nand control pins
    output wire        nand_ce_n,
    output wire        nand_cle,
    output wire        nand_ale,
    output wire        nand_we_n,
    output wire        nand_re_n,
    output wire        nand_wp_n,
    input  wire        nand_rb_n,
    // nand shared io
    output wire [15:0] nand_io_out,
    output wire        nand_io_oe,
    input  wire [15:0] nand_io_in
);
    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_LOAD = 2'h1;
    localparam [1:0] S_RUN  = 2'h2;
    localparam [1:0] S_RB   = 2'h3;

    reg [2:0]  ctrl_q;
    reg [11:0] col_q;
    reg [15:0] row_q;
    reg [15:0] wdata_q;
    reg [15:0] rdata_q;
    reg [7:0]  status_q;
    reg [7:0]  op_cmd_q;
    reg [2:0]  kind_q;
    reg [1:0]  state_q;
    reg [1:0]  step_q;
    reg        cle_q;
    reg        ale_q;
    reg [15:0] io_q;
    reg        oe_q;
    reg        use_re_q;
    reg        start_q;
    reg        rd_ack_q;
    reg [31:0] readdata_q;
    reg [31:0] rd_mux;

    wire       strobe_n;
    wire       sample;
    wire       done;
    wire       x16 = ctrl_q[`NH_CTRL_X16];
    wire       op_hit = avs_write && (avs_address == `NH_OFF_OP);
    wire       op_go = op_hit && (state_q == S_IDLE) && avs_byteenable[1] && avs_byteenable[0];
    wire [2:0] go_kind = avs_writedata[`NH_OP_KIND_MSB:`NH_OP_KIND_LSB];

    // address byte per cycle; column fields by width, row cycles fixed
    function [7:0] addr_byte;
        input [1:0]  idx;
        input        wide;
        input [11:0] col;
        input [15:0] row;
        begin
            case (idx)
                2'h0: addr_byte = col[7:0];
                2'h1: addr_byte = wide ? {5'h00, col[10:8]}
                                       : {4'h0, col[11:8]};
                2'h2: addr_byte = row[7:0];
                default: addr_byte = row[15:8];
            endcase
        end
    endfunction

    // one strobe engine shared by write and read cycles
    nandh_strobe #(
        .LOW_CYC  (LOW_CYC),
        .HIGH_CYC (HIGH_CYC)
    ) u_strobe (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (start_q),
        .strobe_n (strobe_n),
        .sample   (sample),
        .done     (done)
    );

    // pin drive
    assign nand_ce_n   = ~ctrl_q[`NH_CTRL_CE];
    assign nand_wp_n   = ~ctrl_q[`NH_CTRL_PROTECT];
    assign nand_cle    = cle_q;
    assign nand_ale    = ale_q;
    assign nand_we_n   = use_re_q ? 1'b1 : strobe_n;
    assign nand_re_n   = use_re_q ? strobe_n : 1'b1;
    assign nand_io_out = io_q;
    assign nand_io_oe  = oe_q;

    // bus handshake: reads take one wait cycle, op writes stall while busy
    assign avs_waitrequest = (avs_read && !rd_ack_q) || (op_hit && (state_q != S_IDLE));
    assign avs_readdata    = readdata_q;

    // software-written registers, byte lane merge
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q  <= `NH_CTRL_RESET;
            col_q   <= 12'h000;
            row_q   <= 16'h0000;
            wdata_q <= 16'h0000;
        end else if (avs_write) begin
            case (avs_address)
                `NH_OFF_CTRL: begin
                    if (avs_byteenable[0]) ctrl_q <= avs_writedata[2:0];
                end
                `NH_OFF_COLUMN: begin
                    if (avs_byteenable[0]) col_q[7:0]  <= avs_writedata[7:0];
                    if (avs_byteenable[1]) col_q[11:8] <= avs_writedata[11:8];
                end
                `NH_OFF_ROW: begin
                    if (avs_byteenable[0]) row_q[7:0]  <= avs_writedata[7:0];
                    if (avs_byteenable[1]) row_q[15:8] <= avs_writedata[15:8];
                end
                `NH_OFF_WDATA: begin
                    if (avs_byteenable[0]) wdata_q[7:0]  <= avs_writedata[7:0];
                    if (avs_byteenable[1]) wdata_q[15:8] <= avs_writedata[15:8];
                end
                default: begin
                    ctrl_q <= ctrl_q;
                end
            endcase
        end
    end

    // read mux; unmapped offsets read zero
    always @* begin
        rd_mux = 32'h00000000;
        case (avs_address)
            `NH_OFF_CTRL:   rd_mux[2:0]   = ctrl_q;
            `NH_OFF_OP:     rd_mux[10:0]  = {kind_q, op_cmd_q};
            `NH_OFF_COLUMN: rd_mux[11:0]  = col_q;
            `NH_OFF_ROW:    rd_mux[15:0]  = row_q;
            `NH_OFF_WDATA:  rd_mux[15:0]  = wdata_q;
            `NH_OFF_RDATA:  rd_mux[15:0]  = rdata_q;
            `NH_OFF_STATUS: begin
                rd_mux[`NH_ST_BUSY] = (state_q != S_IDLE);
                rd_mux[`NH_ST_RB]   = nand_rb_n;
                rd_mux[`NH_ST_SR_MSB:`NH_ST_SR_LSB] = status_q;
            end
            default: rd_mux = 32'h00000000;
        endcase
    end

    // registered read answer after one wait cycle
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_ack_q   <= 1'b0;
            readdata_q <= 32'h00000000;
        end else if (avs_read && !rd_ack_q) begin
            rd_ack_q   <= 1'b1;
            readdata_q <= rd_mux;
        end else begin
            rd_ack_q <= 1'b0;
        end
    end

    // pin sequencer
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q  <= S_IDLE;
            kind_q   <= `NH_K_CMD;
            op_cmd_q <= 8'h00;
            step_q   <= 2'h0;
            cle_q    <= 1'b0;
            ale_q    <= 1'b0;
            io_q     <= 16'h0000;
            oe_q     <= 1'b0;
            use_re_q <= 1'b0;
            start_q  <= 1'b0;
            rdata_q  <= 16'h0000;
            status_q <= `NH_SR_RESET;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (op_go) begin
                        op_cmd_q <= avs_writedata[`NH_OP_CMD_MSB:0];
                        kind_q   <= go_kind;
                        step_q   <= 2'h0;
                        state_q  <= (go_kind == `NH_K_WAITRB) ? S_RB : S_LOAD;
                    end
                end
                S_LOAD: begin
                    // set up lines one cycle before the strobe falls
                    start_q  <= 1'b1;
                    state_q  <= S_RUN;
                    cle_q    <= 1'b0;
                    ale_q    <= 1'b0;
                    oe_q     <= 1'b1;
                    use_re_q <= 1'b0;
                    io_q     <= 16'h0000;
                    case (kind_q)
                        `NH_K_CMD: begin
                            cle_q <= 1'b1;
                            io_q  <= {8'h00, op_cmd_q};
                        end
                        `NH_K_ADDR: begin
                            ale_q <= 1'b1;
                            io_q  <= {8'h00, addr_byte(step_q, x16, col_q, row_q)};
                        end
                        `NH_K_WRITE: begin
                            io_q <= x16 ? wdata_q : {8'h00, wdata_q[7:0]};
                        end
                        `NH_K_READ: begin
                            oe_q     <= 1'b0;
                            use_re_q <= 1'b1;
                        end
                        default: begin
                            if (step_q == 2'h0) begin
                                cle_q <= 1'b1;
                                io_q  <= {8'h00, `NH_CMD_STATUS};
                            end else begin
                                oe_q     <= 1'b0;
                                use_re_q <= 1'b1;
                            end
                        end
                    endcase
                end
                S_RUN: begin
                    start_q <= 1'b0;
                    if (sample && use_re_q) begin
                        if (kind_q == `NH_K_READ) begin
                            rdata_q <= x16 ? nand_io_in : {8'h00, nand_io_in[7:0]};
                        end else begin
                            status_q <= nand_io_in[7:0];
                        end
                    end
                    if (done) begin
                        cle_q    <= 1'b0;
                        ale_q    <= 1'b0;
                        oe_q     <= 1'b0;
                        use_re_q <= 1'b0;
                        if (kind_q == `NH_K_ADDR && step_q != 2'h3) begin
                            step_q  <= step_q + 2'h1;
                            state_q <= S_LOAD;
                        end else if ((kind_q == `NH_K_STATUS || kind_q == `NH_K_POLL)
                                     && step_q == 2'h0) begin
                            step_q  <= 2'h1;
                            state_q <= S_LOAD;
                        end else if (kind_q == `NH_K_POLL
                                     && !status_q[`NH_SR_ARRAY_IDLE]) begin
                            state_q <= S_LOAD;
                        end else begin
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_RB: begin
                    // wait for the open-drain ready line to be released
                    if (nand_rb_n) begin
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule // nandh_ctrl
`default_nettype wire

// ---- nandh_ctrl_checker.sv ----
// pin and slave-port assertions for the nand host controller
// assumes binding into nandh_ctrl; sees only its ports
`timescale 1ns/10ps
`default_nettype none
module nandh_ctrl_checker #(
    parameter LOW_CYC  = 2,
    parameter HIGH_CYC = 2
) (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // slave port
    input wire logic        avs_read,
    input wire logic        avs_waitrequest,
    // nand pins
    input wire logic        nand_cle,
    input wire logic        nand_ale,
    input wire logic        nand_we_n,
    input wire logic        nand_re_n,
    input wire logic [15:0] nand_io_out,
    input wire logic        nand_io_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // length of the running low strobe phase
    logic [3:0] low_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            low_q <= 4'h0;
        else
            low_q <= (nand_we_n && nand_re_n) ? 4'h0 : low_q + 4'h1;
    end
    latch_exclusive_a: assert property (!(nand_cle && nand_ale))
        else $error("cle and ale high together");
    upper_io_zero_a: assert property ((nand_cle || nand_ale) |-> nand_io_out[15:8] == 8'h00)
        else $error("upper io not low in latch cycle");
    latch_drives_a: assert property ((nand_cle || nand_ale) |-> nand_io_oe && nand_re_n)
        else $error("latch cycle without io drive");
    strobe_exclusive_a: assert property (nand_we_n || nand_re_n)
        else $error("both strobes low");
    read_release_a: assert property (!nand_re_n |-> !nand_io_oe)
        else $error("io driven during read strobe");
    latch_hold_a: assert property (!nand_we_n |-> $stable(nand_cle) && $stable(nand_io_out))
        else $error("latched lines moved under write strobe");
    low_width_a: assert property ($rose(nand_we_n && nand_re_n) |-> low_q == LOW_CYC)
        else $error("strobe low phase of wrong length");
    high_width_a: assert property ($rose(nand_we_n && nand_re_n) |-> (nand_we_n && nand_re_n)[*2])
        else $error("strobe high phase too short");
    read_wait_a: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("read not answered in second cycle");
endmodule // nandh_ctrl_checker
bind nandh_ctrl nandh_ctrl_checker #(.LOW_CYC(LOW_CYC), .HIGH_CYC(HIGH_CYC)) i_nandh_ctrl_checker (
    .core_clk(core_clk), .rst(rst), .avs_read(avs_read), .avs_waitrequest(avs_waitrequest),
    .nand_cle(nand_cle), .nand_ale(nand_ale), .nand_we_n(nand_we_n), .nand_re_n(nand_re_n),
    .nand_io_out(nand_io_out), .nand_io_oe(nand_io_oe));
`default_nettype wire

// ---- nandh_dev_model.sv ----
// behavioural nand device at its pins: latches, page buffer, status byte
// assumes io is the resolved bus level and wide fixes the part's width
`timescale 1ns/10ps
`default_nettype none
module nandh_dev_model #(
    parameter RDY_NS  = 400,
    parameter ARRAY_IDLE_FLAG_NS = 3000
) (
    // part width and control pins
    input wire logic        wide,
    input wire logic        ce_n,
    input wire logic        cle,
    input wire logic        ale,
    input wire logic        we_n,
    input wire logic        re_n,
    input wire logic        wp_n,
    // bus, ready pin, breach flag
    input wire logic [15:0] io,
    output var logic [15:0] io_rd,
    output wire logic       rb_n,
    output var logic        fault
);
    logic [7:0]  a_q [4];
    logic [11:0] col_q;
    logic [15:0] row_q;
    logic [15:0] pbuf [int];
    logic [15:0] mem [int];
    logic        rdy, array_idle_flag, fail, pfail, stat_rd;
    int          acnt;
    // status byte; reserved bits low
    wire [7:0] sr = {wp_n, rdy, array_idle_flag, 3'b000, pfail, fail};
    // pulled up while ready, held low while cache busy
    assign rb_n = rdy;
    initial begin
        {rdy, array_idle_flag, fail, pfail, stat_rd, fault} = 6'b110000;
        {acnt, col_q, row_q, io_rd} = '0;
    end
    // busy windows: cache frees early, array later
    task automatic busy(input int r, input int a);
        rdy = 1'b0;
        array_idle_flag = 1'b0;
        fork
            #(r) rdy = 1'b1;
            #(a) array_idle_flag = 1'b1;
        join_none
    endtask
    // confirm commands act on whole pages or blocks
    task automatic do_cmd(input logic [7:0] c);
        case (c)
            8'h10, 8'h15: begin
                pfail = fail;
                fail = !wp_n;
                if (wp_n) foreach (pbuf[k]) mem[{row_q, k[11:0]}] = pbuf[k];
                pbuf.delete();
                busy(c == 8'h15 ? RDY_NS : ARRAY_IDLE_FLAG_NS, ARRAY_IDLE_FLAG_NS);
            end
            8'h30: busy(RDY_NS, RDY_NS);
            8'hD0: begin
                fail = !wp_n;
                if (wp_n) foreach (mem[k]) if (k[27:18] == row_q[15:6]) mem[k] = 16'hFFFF;
                busy(ARRAY_IDLE_FLAG_NS, ARRAY_IDLE_FLAG_NS);
            end
            default: ;
        endcase
    endtask
    // command, address and data taken on the write strobe rise
    always @(posedge we_n) begin
        if (!ce_n && cle) begin
            stat_rd = (io[7:0] == 8'h70);
            if (!stat_rd) acnt = 0;
            do_cmd(io[7:0]);
        end else if (!ce_n && ale) begin
            if (io[15:8] != 8'h00) fault = 1'b1;
            if (acnt < 4) a_q[acnt] = io[7:0];
            acnt++;
            if (acnt == 2 && (wide ? a_q[1][7:3] : a_q[1][7:4]) != 0) fault = 1'b1;
            col_q = wide ? {1'b0, a_q[1][2:0], a_q[0]} : {a_q[1][3:0], a_q[0]};
            row_q = {a_q[3], a_q[2]};
        end else if (!ce_n) begin
            pbuf[col_q] = wide ? io : {8'h00, io[7:0]};
            col_q++;
        end
    end
    // read data while re_n low; inverted pattern once released
    always @(negedge re_n) begin
        if (!ce_n && stat_rd)
            io_rd = {8'hA5, sr};
        else if (!ce_n)
            io_rd = mem.exists({row_q, col_q}) ? mem[{row_q, col_q}] : 16'hFFFF;
        if (!wide) io_rd[15:8] = 8'hA5;
    end
    always @(posedge re_n) begin
        io_rd = ~io_rd;
        if (!stat_rd) col_q++;
    end
endmodule // nandh_dev_model
`default_nettype wire

// ---- tb_nandh_ctrl.sv ----
// register-level bench for the nand host controller with a device model
// assumes default strobe timing and the register map of nandh_defs.vh
`timescale 1ns/10ps
`default_nettype none
`include "nandh_defs.vh"
module tb_nandh_ctrl;
    logic        core_clk, rst, avs_read, avs_write, wide_q;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, rq;
    logic [3:0]  avs_byteenable;
    logic [11:0] col;
    logic [15:0] row;
    wire  [31:0] avs_readdata;
    wire  [15:0] io_out, dev_io;
    wire         avs_waitrequest, ce_n, cle, ale, we_n, re_n, wp_n, rb_n, io_oe;
    int          miscompares, cmp_count;
    // resolved shared io level
    wire  [15:0] io_w = io_oe ? io_out : dev_io;
    nandh_ctrl i_nandh_ctrl (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale),
        .nand_we_n(we_n), .nand_re_n(re_n), .nand_wp_n(wp_n), .nand_rb_n(rb_n),
        .nand_io_out(io_out), .nand_io_oe(io_oe), .nand_io_in(io_w));
    nandh_dev_model i_dev (.wide(wide_q), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .re_n(re_n), .wp_n(wp_n), .io(io_w), .io_rd(dev_io), .rb_n(rb_n), .fault());
    // 40 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one avalon transfer held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 2000);
        if (n >= 2000) begin
            miscompares++;
            report_and_stop();
        end
        rq = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rq, exp);
    endtask
    // launch one engine operation and wait until it is idle
    task automatic op(input logic [2:0] k, input logic [7:0] c);
        int n;
        n = 0;
        bus(1'b1, `NH_OFF_OP, {21'h0, k, c});
        do begin
            bus(1'b0, `NH_OFF_STATUS, 32'h0);
            n++;
        end while (rq[`NH_ST_BUSY] !== 1'b0 && n < 400);
        if (n >= 400) begin
            miscompares++;
            report_and_stop();
        end
    endtask
    task automatic prog(input logic [15:0] d, input logic [7:0] c);
        op(`NH_K_CMD, 8'h80);
        op(`NH_K_ADDR, 8'h00);
        bus(1'b1, `NH_OFF_WDATA, {16'h0, d});
        op(`NH_K_WRITE, 8'h00);
        op(`NH_K_CMD, c);
    endtask
    task automatic page_read();
        op(`NH_K_CMD, 8'h00);
        op(`NH_K_ADDR, 8'h00);
        op(`NH_K_CMD, 8'h30);
        op(`NH_K_WAITRB, 8'h00);
        op(`NH_K_READ, 8'h00);
    endtask
    initial begin
        {rst, avs_read, avs_write, wide_q} = 4'b1000;
        {avs_address, avs_writedata, avs_byteenable} = {37'h0, 4'h3};
        {miscompares, cmp_count} = '0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(`NH_OFF_STATUS, 32'h0000E002);
        rd(5'h1C, 32'h0);
        bus(1'b1, `NH_OFF_CTRL, 32'h4);
        op(`NH_K_STATUS, `NH_CMD_STATUS);
        rd(`NH_OFF_STATUS, 32'h0000E002);
        for (int w = 0; w < 2; w++) begin
            wide_q <= w[0];
            col = w[0] ? 12'h7C5 : 12'hF3C;
            row = w[0] ? 16'h0041 : 16'hFFC1;
            bus(1'b1, `NH_OFF_CTRL, {29'h0, 2'b10, w[0]});
            bus(1'b1, `NH_OFF_COLUMN, {20'h0, col});
            bus(1'b1, `NH_OFF_ROW, {16'h0, row});
            prog(16'hC35A, 8'h10);
            chk(i_dev.col_q, col + 12'h1);
            chk(i_dev.row_q, row);
            op(`NH_K_POLL, `NH_CMD_STATUS);
            rd(`NH_OFF_STATUS, 32'h0000E002);
            page_read();
            rd(`NH_OFF_RDATA, w[0] ? 32'hC35A : 32'h005A);
        end
        // block erase leaves the page blank
        op(`NH_K_CMD, 8'h60);
        op(`NH_K_ADDR, 8'h00);
        op(`NH_K_CMD, 8'hD0);
        op(`NH_K_POLL, `NH_CMD_STATUS);
        page_read();
        rd(`NH_OFF_RDATA, 32'h0000FFFF);
        // cache program: ready pin returns before the array
        prog(16'h1234, 8'h15);
        op(`NH_K_WAITRB, 8'h00);
        op(`NH_K_STATUS, `NH_CMD_STATUS);
        rd(`NH_OFF_STATUS, 32'h0000C002);
        op(`NH_K_POLL, `NH_CMD_STATUS);
        rd(`NH_OFF_STATUS, 32'h0000E002);
        // protected part refuses program
        bus(1'b1, `NH_OFF_CTRL, 32'h7);
        chk(wp_n, 1'b0);
        prog(16'h4321, 8'h10);
        op(`NH_K_POLL, `NH_CMD_STATUS);
        rd(`NH_OFF_STATUS, 32'h00006102);
        chk(i_dev.fault, 1'b0);
        report_and_stop();
    end
endmodule // tb_nandh_ctrl
`default_nettype wire
